// File: logic/suspend_wake_cfg.svh
// Timing counts and bit positions for the suspend and wake controller
`ifndef SUSPEND_WAKE_CFG_SVH
`define SUSPEND_WAKE_CFG_SVH
`define CLK_MHZ 125
`define IDLE_TIME_US 3000
`define IDLE_CYCLES (`IDLE_TIME_US * `CLK_MHZ)
`define ENTRY_TIME_US 500
`define ENTRY_CYCLES (`ENTRY_TIME_US * `CLK_MHZ)
`define RESUME_TIME_US 10000
`define RESUME_CYCLES (`RESUME_TIME_US * `CLK_MHZ)
`define SLEEP_REQ_BIT 3
`define RESUME_SEEN_BIT 2
`define IDLE_CHANGE_BIT 1
`endif

// File: logic/suspend_wake_pkg.sv
// Types shared by the suspend and wake controller
`default_nettype none
package suspend_wake_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_ENTRY = 4'h2,
    ST_SUSPENDED = 4'h4,
    ST_STANDBY = 4'h8
  } power_state_type;
endpackage
`default_nettype wire

// File: logic/cycle_timer.sv
// Loadable down counter that pulses once when it expires
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load_value,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count_q;

  // Start restarts a running count; stop has lower priority than start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= load_value;
        busy <= 1'b1;
      end else if (stop) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count_q <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end
endmodule // cycle_timer
`default_nettype wire

// File: logic/usb_device_suspend_wake_control.sv
// Suspend entry, wake-up and resume control of a USB device interface
`include "suspend_wake_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module usb_device_suspend_wake_control #(
  parameter int IDLE_CYCLES = `IDLE_CYCLES,
  parameter int ENTRY_CYCLES = `ENTRY_CYCLES,
  parameter int RESUME_CYCLES = `RESUME_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_activity,
  input wire logic bus_nonidle,
  input wire logic lines_idle_j,
  input wire logic host_suspend_req,
  input wire logic vbus,
  input wire logic chip_select_n,
  input wire logic attach_enable,
  input wire logic host_wake_enable,
  input wire logic pin_wake_enable,
  input wire logic idle_irq_enable,
  input wire logic resume_irq_enable,
  input wire logic [7:0] status_write,
  input wire logic send_resume_write,
  output logic [7:0] irq_status_high,
  output logic local_irq,
  output logic osc_enable,
  output logic local_clock_out_enable,
  output logic pins_hiz,
  output logic resume_drive,
  output logic detached,
  output logic suspended
);
  // State and flag registers; the outputs except resume_drive and detached are decoded from them
  suspend_wake_pkg::power_state_type state_q;
  logic idle_change_q;
  logic resume_seen_q;
  logic sleep_req_q;
  logic standby_seen_q;
  logic idle_busy;
  logic idle_done;
  logic entry_busy;
  logic entry_done;
  logic resume_busy;
  logic idle_set;
  logic host_wake;
  logic pin_wake;
  logic attach_wake;
  logic wake;
  logic sleep_cmd;
  logic forced_q;

  // Detached when unplugged or when software disables attach; VBUS is only a presence sense
  // detach decode
  assign detached = !vbus || !attach_enable;
  assign sleep_cmd = status_write[`SLEEP_REQ_BIT];

  // Idle timer is rearmed by every bus event
  // It is held off while the idle flag is pending, so one quiet spell raises one event
  // idle timer
  cycle_timer #(.WIDTH(32)) idle_timer (
    .clk(clk),
    .nrst(nrst),
    .start(bus_activity || (state_q == suspend_wake_pkg::ST_RUN && !idle_busy && !idle_change_q && !idle_done)),
    .stop(state_q != suspend_wake_pkg::ST_RUN),
    .load_value(32'(IDLE_CYCLES)),
    .busy(idle_busy),
    .done(idle_done)
  );

  assign idle_set = idle_done || ((!vbus || (detached && lines_idle_j)) && state_q == suspend_wake_pkg::ST_RUN);

  // Entry delay keeps the local clock alive so a clocked CPU can finish
  // entry delay
  cycle_timer #(.WIDTH(32)) entry_timer (
    .clk(clk),
    .nrst(nrst),
    .start(state_q == suspend_wake_pkg::ST_RUN && sleep_cmd),
    .stop(1'b0),
    .load_value(32'(ENTRY_CYCLES)),
    .busy(entry_busy),
    .done(entry_done)
  );

  // Resume is only sent from run; a write while suspended is dropped, the CPU has no clock then
  // resume length
  cycle_timer #(.WIDTH(32)) resume_timer (
    .clk(clk),
    .nrst(nrst),
    .start(send_resume_write && state_q == suspend_wake_pkg::ST_RUN),
    .stop(1'b0),
    .load_value(32'(RESUME_CYCLES)),
    .busy(resume_busy),
    .done()
  );
  // Resume drive comes straight from the timer flop, so it has no decode glitch
  assign resume_drive = resume_busy;

  // Wake sources are only looked at once truly suspended
  // Host wake also needs VBUS so a floating bus cannot wake a detached device
  // host wake gating
  assign host_wake = bus_nonidle && vbus && attach_enable && host_wake_enable;
  assign pin_wake = !chip_select_n && pin_wake_enable;
  // A suspend forced while detached ends once the cable and attach enable are both back;
  // an ordinary suspend taken while attached must not, or it would end the moment it began
  // reattach wake
  assign attach_wake = forced_q && !detached;
  assign wake = state_q == suspend_wake_pkg::ST_SUSPENDED && (host_wake || pin_wake || attach_wake);

  // Power state sequence; standby is caught at the first edge after reset release
  // exit only wake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= suspend_wake_pkg::ST_RUN;
      standby_seen_q <= 1'b0;
    end else begin
      standby_seen_q <= 1'b1;
      case (state_q)
        suspend_wake_pkg::ST_RUN: begin
          if (!standby_seen_q && !chip_select_n) begin
            state_q <= suspend_wake_pkg::ST_STANDBY;
          end else if (sleep_cmd) begin
            state_q <= suspend_wake_pkg::ST_ENTRY;
          end
        end
        suspend_wake_pkg::ST_ENTRY: begin
          if (entry_done) begin
            state_q <= suspend_wake_pkg::ST_SUSPENDED;
          end
        end
        suspend_wake_pkg::ST_SUSPENDED: begin
          if (wake) begin
            state_q <= suspend_wake_pkg::ST_RUN;
          end
        end
        // Standby lasts until the board resets the device again
        // The board keeps reset low long enough for the oscillator to settle
        suspend_wake_pkg::ST_STANDBY: begin
          state_q <= suspend_wake_pkg::ST_STANDBY;
        end
        default: begin
          state_q <= suspend_wake_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Forced-suspend marker: taken when suspend is commanded while detached, dropped back in run
  // forced suspend
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      forced_q <= 1'b0;
    end else if (state_q == suspend_wake_pkg::ST_RUN) begin
      forced_q <= sleep_cmd && detached;
    end
  end

  // Sticky flags: hardware set wins over a same-cycle write-one clear
  // An event and a clear in one cycle keep the flag set, so no event is lost
  // write one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_change_q <= 1'b0;
      resume_seen_q <= 1'b0;
      sleep_req_q <= 1'b0;
    end else begin
      if (idle_set) begin
        idle_change_q <= 1'b1;
      end else if (status_write[`IDLE_CHANGE_BIT]) begin
        idle_change_q <= 1'b0;
      end
      if (wake) begin
        resume_seen_q <= 1'b1;
      end else if (status_write[`RESUME_SEEN_BIT]) begin
        resume_seen_q <= 1'b0;
      end
      if (host_suspend_req || idle_done) begin
        sleep_req_q <= 1'b1;
      end else if (sleep_cmd) begin
        sleep_req_q <= 1'b0;
      end
    end
  end

  always_comb begin
    irq_status_high = 8'h00;
    irq_status_high[`IDLE_CHANGE_BIT] = idle_change_q;
    irq_status_high[`RESUME_SEEN_BIT] = resume_seen_q;
    irq_status_high[`SLEEP_REQ_BIT] = sleep_req_q;
  end

  // Power outputs follow the state
  // stop oscillator
  assign suspended = state_q == suspend_wake_pkg::ST_SUSPENDED || state_q == suspend_wake_pkg::ST_STANDBY;
  assign osc_enable = !suspended;
  assign pins_hiz = suspended;
  assign local_clock_out_enable = !suspended;
  // Interrupt line is a plain level; masking is done by the enables only
  assign local_irq = (idle_change_q && idle_irq_enable) || (resume_seen_q && resume_irq_enable);

  // Power-sequence checks; they watch only what this block drives
  AST_ENTRY_DELAY: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_RUN && sleep_cmd && !(!standby_seen_q && !chip_select_n)
      |=> state_q == suspend_wake_pkg::ST_ENTRY && osc_enable)
    else $error("entry not started with clock running");
  AST_NO_EARLY_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_ENTRY && !entry_done |=> state_q != suspend_wake_pkg::ST_RUN)
    else $error("woke during entry delay");
  AST_SUSP_HIZ: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED |-> !osc_enable && pins_hiz)
    else $error("suspended with oscillator running");
  AST_EXIT_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && !wake |=> state_q == suspend_wake_pkg::ST_SUSPENDED)
    else $error("left suspend without wake");
  AST_HOST_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && bus_nonidle && vbus && attach_enable && host_wake_enable
      |=> state_q == suspend_wake_pkg::ST_RUN)
    else $error("host wake missed");
  AST_PIN_WAKE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && !chip_select_n && pin_wake_enable |=> osc_enable)
    else $error("pin wake missed");
  AST_RESUME_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    wake |=> resume_seen_q)
    else $error("resume flag not set");
  AST_RESUME_LEN: assert property (@(posedge clk) disable iff (!nrst)
    send_resume_write && state_q == suspend_wake_pkg::ST_RUN |=> resume_drive [*8])
    else $error("resume signalling too short");
  AST_IDLE_SET: assert property (@(posedge clk) disable iff (!nrst)
    idle_done |=> idle_change_q)
    else $error("idle flag not set");
  AST_DETACH: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && !attach_enable && chip_select_n
      |=> state_q == suspend_wake_pkg::ST_SUSPENDED)
    else $error("attach disable ignored");

  // Entry, standby, reattach and host-wake oscillator checks
  AST_ENTRY_CLOCK: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_ENTRY |-> local_clock_out_enable && (entry_busy || entry_done))
    else $error("local clock stopped during entry delay");
  AST_ENTRY_PIN: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_ENTRY && pin_wake && !entry_done |=> state_q == suspend_wake_pkg::ST_ENTRY)
    else $error("pin wake taken during entry delay");
  AST_STANDBY_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_STANDBY |=> state_q == suspend_wake_pkg::ST_STANDBY && !osc_enable)
    else $error("standby left without reset");
  AST_REATTACH: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && forced_q && !detached
      |=> state_q == suspend_wake_pkg::ST_RUN && resume_seen_q)
    else $error("reattach did not end forced suspend");
  AST_HOST_OSC: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_SUSPENDED && host_wake |=> osc_enable)
    else $error("host wake left oscillator stopped");

  // Flag and interrupt checks
  AST_DETACH_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    state_q == suspend_wake_pkg::ST_RUN && !vbus |=> idle_change_q)
    else $error("idle flag not set without cable power");
  AST_SLEEP_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    host_suspend_req |=> sleep_req_q)
    else $error("sleep request flag not set");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    idle_change_q && !status_write[`IDLE_CHANGE_BIT] |=> idle_change_q)
    else $error("idle flag cleared without a write");
  AST_IDLE_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    idle_change_q && idle_irq_enable |-> local_irq)
    else $error("idle interrupt missing");
  AST_RESUME_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    resume_seen_q && resume_irq_enable |-> local_irq)
    else $error("resume interrupt missing");
endmodule // usb_device_suspend_wake_control
`default_nettype wire

// File: dv/host_bus_model.sv
// Behavioural host side of the bus: line states and cable power
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  output logic bus_activity,
  output logic bus_nonidle,
  output logic lines_idle_j,
  output logic vbus
);
  // Plugged in and quiet from time zero
  initial begin
    bus_activity = 1'b0;
    bus_nonidle = 1'b0;
    lines_idle_j = 1'b0;
    vbus = 1'b1;
  end
  task automatic plug(input logic on);
    @(negedge clk);
    vbus = on;
    lines_idle_j = !on; // Pull-up leaves idle J once no host drives
  endtask
  // traffic keeps the idle timer rearmed
  task automatic traffic(input int n);
    repeat (n) begin
      @(negedge clk);
      bus_activity = 1'b1;
    end
    @(negedge clk);
    bus_activity = 1'b0;
  endtask
  // host resume drives a non-idle state
  task automatic drive_nonidle(input logic on);
    @(negedge clk);
    bus_nonidle = on;
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: dv/usb_device_suspend_wake_control_tb.sv
// Self-checking bench for the suspend and wake controller
`timescale 1ns/100ps
`default_nettype none
module usb_device_suspend_wake_control_tb;
  // Short counts keep the run brief
  localparam int IDLE_N = 20;
  localparam int ENTRY_N = 10;
  localparam int RESUME_N = 30;
  logic clk, nrst, bus_activity, bus_nonidle, lines_idle_j, vbus, chip_select_n, attach_enable;
  logic host_wake_enable, pin_wake_enable, idle_irq_enable, resume_irq_enable, send_resume_write;
  logic host_suspend_req;
  logic [7:0] status_write, irq_status_high;
  logic local_irq, osc_enable, local_clock_out_enable, pins_hiz, resume_drive, detached, suspended;
  int failures, checks_done, n;
  host_bus_model host (.clk(clk), .bus_activity(bus_activity), .bus_nonidle(bus_nonidle),
    .lines_idle_j(lines_idle_j), .vbus(vbus));
  usb_device_suspend_wake_control #(.IDLE_CYCLES(IDLE_N), .ENTRY_CYCLES(ENTRY_N), .RESUME_CYCLES(RESUME_N)) dut (
    .clk(clk), .nrst(nrst), .bus_activity(bus_activity), .bus_nonidle(bus_nonidle),
    .lines_idle_j(lines_idle_j), .host_suspend_req(host_suspend_req), .vbus(vbus), .chip_select_n(chip_select_n),
    .attach_enable(attach_enable), .host_wake_enable(host_wake_enable), .pin_wake_enable(pin_wake_enable),
    .idle_irq_enable(idle_irq_enable), .resume_irq_enable(resume_irq_enable), .status_write(status_write),
    .send_resume_write(send_resume_write), .irq_status_high(irq_status_high), .local_irq(local_irq),
    .osc_enable(osc_enable), .local_clock_out_enable(local_clock_out_enable), .pins_hiz(pins_hiz),
    .resume_drive(resume_drive), .detached(detached), .suspended(suspended));
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // One-cycle write-one strobe, launched after a falling edge
  task automatic write_status(input logic [7:0] v);
    status_write = v;
    tick(1);
    status_write = 8'h00;
  endtask
  // Bounded waits; a miss ends the run
  task automatic await_susp(input logic v, input int lim);
    for (int i = 0; i < lim && suspended !== v; i++) tick(1);
    chk_bit(suspended, v);
    if (suspended !== v) give_verdict();
  endtask
  task automatic await_flag(input int b, input int lim);
    for (int i = 0; i < lim && irq_status_high[b] !== 1'b1; i++) tick(1);
    chk_bit(irq_status_high[b], 1'b1);
    if (irq_status_high[b] !== 1'b1) give_verdict();
  endtask
  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    nrst = 1'b0;
    chip_select_n = 1'b1;
    attach_enable = 1'b1;
    host_wake_enable = 1'b0;
    pin_wake_enable = 1'b1;
    idle_irq_enable = 1'b0;
    resume_irq_enable = 1'b0;
    status_write = 8'h00;
    send_resume_write = 1'b0;
    host_suspend_req = 1'b0;
    tick(5);
    chk_byte(irq_status_high, 8'h00);
    chk_bit(osc_enable, 1'b1);
    nrst = 1'b1;
    tick(2);
    host_suspend_req = 1'b1;
    tick(1);
    host_suspend_req = 1'b0;
    chk_bit(irq_status_high[3], 1'b1);
    host.traffic(IDLE_N + 5);
    chk_byte(irq_status_high, 8'h08);
    tick(IDLE_N - 3);
    chk_bit(irq_status_high[1], 1'b0);
    await_flag(1, 8);
    chk_byte(irq_status_high, 8'h0A);
    chk_bit(local_irq, 1'b0);
    idle_irq_enable = 1'b1;
    tick(1);
    chk_bit(local_irq, 1'b1);
    write_status(8'h02);
    chk_bit(irq_status_high[1], 1'b0);
    chk_bit(local_irq, 1'b0);
    idle_irq_enable = 1'b0;
    write_status(8'h08);
    chk_bit(irq_status_high[3], 1'b0);
    tick(ENTRY_N / 2);
    chk_bit(local_clock_out_enable, 1'b1);
    chip_select_n = 1'b0;
    tick(1);
    chip_select_n = 1'b1;
    chk_bit(suspended, 1'b0);
    await_susp(1'b1, ENTRY_N + 4);
    chk_bit(osc_enable, 1'b0);
    chk_bit(pins_hiz, 1'b1);
    chk_bit(irq_status_high[2], 1'b0);
    host.drive_nonidle(1'b1);
    tick(4);
    chk_bit(suspended, 1'b1);
    host_wake_enable = 1'b1;
    resume_irq_enable = 1'b1;
    await_susp(1'b0, 4);
    chk_bit(irq_status_high[2], 1'b1);
    chk_bit(local_irq, 1'b1);
    host.drive_nonidle(1'b0);
    write_status(8'h04);
    chk_bit(irq_status_high[2], 1'b0);
    pin_wake_enable = 1'b0;
    write_status(8'h08);
    await_susp(1'b1, ENTRY_N + 4);
    chip_select_n = 1'b0;
    tick(4);
    chk_bit(suspended, 1'b1);
    pin_wake_enable = 1'b1;
    await_susp(1'b0, 4);
    chk_bit(irq_status_high[2], 1'b1);
    chip_select_n = 1'b1;
    tick(4);
    send_resume_write = 1'b1;
    tick(1);
    send_resume_write = 1'b0;
    n = 0;
    while (resume_drive === 1'b1 && n < RESUME_N + 5) begin
      tick(1);
      n++;
    end
    chk_byte(n[7:0], 8'(RESUME_N));
    chk_bit(irq_status_high[3], 1'b1);
    chk_bit(suspended, 1'b0);
    write_status(8'h02);
    chk_bit(irq_status_high[1], 1'b0);
    host.plug(1'b0);
    tick(1);
    chk_bit(detached, 1'b1);
    await_flag(1, 6);
    attach_enable = 1'b0;
    write_status(8'h0E);
    await_susp(1'b1, ENTRY_N + 4);
    host.plug(1'b1);
    tick(1);
    chk_bit(detached, 1'b1);
    tick(3);
    chk_bit(suspended, 1'b1);
    attach_enable = 1'b1;
    await_susp(1'b0, 4);
    chk_bit(irq_status_high[2], 1'b1);
    nrst = 1'b0;
    chip_select_n = 1'b0;
    tick(5);
    nrst = 1'b1;
    tick(3);
    chk_bit(osc_enable, 1'b0);
    chip_select_n = 1'b1;
    tick(3);
    chk_bit(suspended, 1'b1);
    chk_bit(osc_enable, 1'b0);
    nrst = 1'b0;
    tick(5);
    nrst = 1'b1;
    tick(3);
    chk_bit(osc_enable, 1'b1);
    give_verdict();
  end
endmodule // usb_device_suspend_wake_control_tb
`default_nettype wire
